// ---- logic/pchr_regs.sv ----
// PCI configuration header slice: interrupt pin, I/O and memory windows,
// tenure timer, grant/latency values and capability next pointer.
// Assumes configuration cycles arrive already decoded to dword and byte
// enables, and that FRAME#/GNT# levels are synchronous to clock_i.
// Limitation: only the fields of this slice are decoded; every other
// configuration dword reads zero and ignores writes.
// Auto-initialization is one parm_load_i pulse per parameter word.
//
// Behaviour
// - Interrupt pin reads 0x01, line A only
// - I/O window bits 31..7 writable, 128 bytes
// - I/O window bit 0 reads one; 6..1 reserved
// - Tenure timer 0x0d, bits 7..3, 8-clock units
// - Tenure counter reloads on each FRAME# start
// - Expired and GNT# removed: end the transaction
// - Max latency 0x3f read-only, default 0x0a
// - Auto-init replaces max latency bits 5..1
// - Min grant 0x3e read-only, default 0x00
// - Auto-init loads min grant bits 7..4
// - Memory window disabled by parameter word
// - Memory window bit 0 is valid indicator
// - Map kind bits 2..1; bit 1 from EEPROM
// - Memory window bits 31..7 writable, 128 bytes
// - Capability next pointer 0x51 reads 0x00
`timescale 1ns/1ps
`default_nettype none

module pchr_regs
  import pchr_pkg::*;
(
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  // Configuration access
  input  wire pchr_cfg_req_s cfg_req_i,
  output logic               cfg_ack_o,
  output logic [31:0]        cfg_rdata_o,
  // Auto-initialization
  input  wire logic          parm_load_i,
  input  wire logic [15:0]   eeprom_parameter_word_i,
  // Bus master tenure
  input  wire logic          frame_start_i,
  input  wire logic          master_active_i,
  input  wire logic          gnt_n_i,
  output logic               tenure_expired_o,
  output logic               master_end_o,
  // Interrupt
  input  wire logic          irq_req_i,
  output logic               inta_n_o,
  output logic               inta_n_oe_o,
  // Decode windows
  output logic [31:0]        io_window_base_o,
  output logic [31:0]        memory_window_base_o,
  output logic               memory_window_enable_o,
  output logic               below_one_megabyte_flag_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  bus_tenure_timer;
    logic [24:0] io_base_hi;
    logic [24:0] mem_base_hi;
    logic [7:0]  min_burst_grant;
    logic [7:0]  max_access_latency;
    logic        mem_disabled;
    logic        below_1m;
    logic [7:0]  tenure_cnt;
    logic        expired;
    logic        master_end;
    logic        ack;
    logic [31:0] rdata;
    logic        inta_oe;
    logic        mem_enable;
    logic        inta_level;
  } pchr_state_s;

  pchr_state_s state_q;
  pchr_state_s state_d;

  // ----------------------------------------------------------------
  // Read-side views of the I/O and memory window registers
  // ----------------------------------------------------------------
  logic [31:0] io_window_word;
  logic [31:0] mem_window_word;
  logic [1:0]  memory_map_kind;
  logic        io_window_flag;
  logic        memory_window_flag;

  // Bit 2 of the map kind is tied low; bit 1 set means below 1MB
  assign memory_map_kind    = {1'b0, state_q.below_1m};
  assign io_window_flag     = 1'b1;
  assign memory_window_flag = 1'b1;

  // Reserved bits 6..1 and 6..3 fold to zero here
  assign io_window_word = {state_q.io_base_hi, 6'h00, io_window_flag};
  // A disabled window reads all zero, so the host sizes it as absent
  assign mem_window_word = state_q.mem_disabled ? 32'h00000000 :
                           {state_q.mem_base_hi, 4'h0, memory_map_kind,
                            memory_window_flag};

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] place_byte(input logic [7:0] off,
                                             input logic [7:0] val);
    logic [31:0] w;
    w = 32'h00000000;
    w[8*off[1:0] +: 8] = val;
    return w;
  endfunction : place_byte

  function automatic logic [31:0] read_dword(input logic [5:0]  dw,
                                             input pchr_state_s s,
                                             input logic [31:0] io_w,
                                             input logic [31:0] mem_w);
    logic [31:0] r;
    r = 32'h00000000;
    if (dw == BUS_TENURE_TIMER_OFF[7:2]) begin
      r = r | place_byte(BUS_TENURE_TIMER_OFF, s.bus_tenure_timer & TENURE_TIMER_WMASK);
    end
    if (dw == IO_WINDOW_BASE_OFF[7:2]) begin
      r = r | io_w;
    end
    if (dw == MEMORY_WINDOW_BASE_OFF[7:2]) begin
      r = r | mem_w;
    end
    if (dw == IRQ_LINE_SELECT_OFF[7:2]) begin
      r = r | place_byte(IRQ_LINE_SELECT_OFF, IRQ_LINE_SELECT_VAL);
    end
    if (dw == MIN_BURST_GRANT_OFF[7:2]) begin
      r = r | place_byte(MIN_BURST_GRANT_OFF, s.min_burst_grant);
    end
    if (dw == MAX_ACCESS_LATENCY_OFF[7:2]) begin
      r = r | place_byte(MAX_ACCESS_LATENCY_OFF, s.max_access_latency);
    end
    if (dw == CAPABILITY_NEXT_POINTER_OFF[7:2]) begin
      r = r | place_byte(CAPABILITY_NEXT_POINTER_OFF, CAPABILITY_NEXT_POINTER_VAL);
    end
    return r;
  endfunction : read_dword

  // ----------------------------------------------------------------
  // Byte lanes
  // ----------------------------------------------------------------
  logic [31:0] lane_mask;

  // One enable per byte lane, spread over its eight data bits
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_mask[8*g +: 8] = {8{cfg_req_i.be[g]}};
  end

  // Byte-enable merge restricted to the writable mask
  function automatic logic [31:0] merge_word(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [31:0] lanes,
                                             input logic [31:0] wmask);
    logic [31:0] m;
    m = lanes & wmask;
    return (old_v & ~m) | (new_v & m);
  endfunction : merge_word

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        cfg_wr;
  logic        cfg_rd;
  logic        wr_tenure;
  logic        wr_io_window;
  logic        wr_mem_window;
  logic [7:0]  max_lat_load;
  logic [7:0]  min_gnt_load;
  logic [31:0] io_merged;
  logic [31:0] mem_merged;
  logic [7:0]  tmr_byte;
  logic        tmr_be;

  always_comb begin
    state_d = state_q;

    cfg_wr        = cfg_req_i.req & cfg_req_i.we;
    cfg_rd        = cfg_req_i.req & ~cfg_req_i.we;
    wr_tenure     = cfg_wr & (cfg_req_i.dword == BUS_TENURE_TIMER_OFF[7:2]);
    wr_io_window  = cfg_wr & (cfg_req_i.dword == IO_WINDOW_BASE_OFF[7:2]);
    wr_mem_window = cfg_wr & (cfg_req_i.dword == MEMORY_WINDOW_BASE_OFF[7:2]);
    io_merged     = merge_word({state_q.io_base_hi, 7'h00}, cfg_req_i.wdata,
                               lane_mask, WINDOW_BASE_WMASK);
    mem_merged    = merge_word({state_q.mem_base_hi, 7'h00}, cfg_req_i.wdata,
                               lane_mask, WINDOW_BASE_WMASK);
    tmr_byte      = cfg_req_i.wdata[8*BUS_TENURE_TIMER_OFF[1:0] +: 8];
    tmr_be        = cfg_req_i.be[BUS_TENURE_TIMER_OFF[1:0]];
    // Parameter word fields already placed at their register bit positions
    max_lat_load  = {2'b00, eeprom_parameter_word_i[PARM_MAX_LAT_LSB +: 5], 1'b0};
    min_gnt_load  = {eeprom_parameter_word_i[PARM_MIN_GNT_LSB +: 4], 4'h0};

    // --------------------------------------------------------------
    // Configuration answer
    // --------------------------------------------------------------
    // One-cycle answer for reads and writes alike
    state_d.ack   = cfg_req_i.req;
    state_d.rdata = 32'h00000000;
    if (cfg_rd) begin
      state_d.rdata = read_dword(cfg_req_i.dword, state_q, io_window_word, mem_window_word);
    end

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    if (wr_tenure && tmr_be) begin
      state_d.bus_tenure_timer = tmr_byte & TENURE_TIMER_WMASK;
    end
    if (wr_io_window) begin
      state_d.io_base_hi = io_merged[31:7];
    end
    // Writes to a disabled memory window are dropped
    if (wr_mem_window && !state_q.mem_disabled) begin
      state_d.mem_base_hi = mem_merged[31:7];
    end

    // --------------------------------------------------------------
    // Auto-initialization from the EEPROM parameter word
    // --------------------------------------------------------------
    // Placed after the writes, so a disabling load beats a window write
    if (parm_load_i) begin
      state_d.max_access_latency = (state_q.max_access_latency & ~MAX_LAT_LOAD_MASK) |
                                   (max_lat_load & MAX_LAT_LOAD_MASK);
      state_d.min_burst_grant    = (state_q.min_burst_grant & ~MIN_GNT_LOAD_MASK) |
                                   (min_gnt_load & MIN_GNT_LOAD_MASK);
      state_d.mem_disabled = eeprom_parameter_word_i[PARM_MEM_DIS_BIT];
      state_d.below_1m     = eeprom_parameter_word_i[PARM_BELOW_1M_BIT];
      if (eeprom_parameter_word_i[PARM_MEM_DIS_BIT]) begin
        state_d.mem_base_hi = MEMORY_WINDOW_BASE_RST[31:7];
      end
    end
    // Registered copy keeps the enable output free of logic
    state_d.mem_enable = !state_d.mem_disabled;

    // --------------------------------------------------------------
    // Tenure counter, loaded in 8-clock units at every FRAME# assertion
    // --------------------------------------------------------------
    // A fresh FRAME# wins over the running count; a zero timer expires at once
    if (frame_start_i) begin
      state_d.tenure_cnt = state_q.bus_tenure_timer & TENURE_TIMER_WMASK;
      state_d.expired    = ((state_q.bus_tenure_timer & TENURE_TIMER_WMASK) == 8'h00);
    end else if (master_active_i && !state_q.expired) begin
      state_d.tenure_cnt = state_q.tenure_cnt - 8'h01;
      state_d.expired    = (state_q.tenure_cnt == 8'h01);
    end else if (!master_active_i) begin
      state_d.expired = 1'b0;
    end

    // --------------------------------------------------------------
    // Master end and interrupt drive
    // --------------------------------------------------------------
    // Grant removed after expiry ends the tenure at once
    state_d.master_end = master_active_i && state_q.expired && gnt_n_i;

    // Only line A is ever driven, low while a request stands
    state_d.inta_oe    = irq_req_i;
    // Open drain: the pin level is always low, only the enable moves
    state_d.inta_level = 1'b0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q.bus_tenure_timer   <= BUS_TENURE_TIMER_RST;
      state_q.io_base_hi         <= IO_WINDOW_BASE_RST[31:7];
      state_q.mem_base_hi        <= MEMORY_WINDOW_BASE_RST[31:7];
      state_q.min_burst_grant    <= MIN_BURST_GRANT_RST;
      state_q.max_access_latency <= MAX_ACCESS_LATENCY_RST;
      state_q.mem_disabled       <= 1'b0;
      state_q.below_1m           <= 1'b0;
      state_q.tenure_cnt         <= 8'h00;
      state_q.expired            <= 1'b0;
      state_q.master_end         <= 1'b0;
      state_q.ack                <= 1'b0;
      state_q.rdata              <= 32'h00000000;
      state_q.inta_oe            <= 1'b0;
      state_q.mem_enable         <= 1'b1;
      state_q.inta_level         <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg_ack_o                 = state_q.ack;
  assign cfg_rdata_o               = state_q.rdata;
  assign tenure_expired_o          = state_q.expired;
  assign master_end_o              = state_q.master_end;
  assign inta_n_o                  = state_q.inta_level;
  assign inta_n_oe_o               = state_q.inta_oe;
  assign io_window_base_o          = {state_q.io_base_hi, 7'h00};
  assign memory_window_base_o      = {state_q.mem_base_hi, 7'h00};
  assign memory_window_enable_o    = state_q.mem_enable;
  assign below_one_megabyte_flag_o = state_q.below_1m;

endmodule : pchr_regs

`default_nettype wire

// ---- logic/pchr_pkg.sv ----
// Package for the PCI configuration header register slice.
// Assumes a dword-addressed configuration access port with byte enables,
// driven by the device's PCI target logic on the PCI clock.
`default_nettype none

package pchr_pkg;

  // ----------------------------------------------------------------
  // Byte offsets in configuration space
  // ----------------------------------------------------------------
  localparam logic [7:0] BUS_TENURE_TIMER_OFF        = 8'h0d;
  localparam logic [7:0] IO_WINDOW_BASE_OFF          = 8'h10;
  localparam logic [7:0] MEMORY_WINDOW_BASE_OFF      = 8'h14;
  localparam logic [7:0] IRQ_LINE_SELECT_OFF         = 8'h3d;
  localparam logic [7:0] MIN_BURST_GRANT_OFF         = 8'h3e;
  localparam logic [7:0] MAX_ACCESS_LATENCY_OFF      = 8'h3f;
  localparam logic [7:0] CAPABILITY_NEXT_POINTER_OFF = 8'h51;

  // ----------------------------------------------------------------
  // Reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [7:0]  BUS_TENURE_TIMER_RST        = 8'h00;
  localparam logic [31:0] MEMORY_WINDOW_BASE_RST      = 32'h00000000;
  localparam logic [31:0] IO_WINDOW_BASE_RST          = 32'h00000000;
  localparam logic [7:0]  MIN_BURST_GRANT_RST         = 8'h00;
  localparam logic [7:0]  MAX_ACCESS_LATENCY_RST      = 8'h0a;
  localparam logic [7:0]  CAPABILITY_NEXT_POINTER_VAL = 8'h00;
  localparam logic [7:0]  IRQ_LINE_SELECT_VAL         = 8'h01;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam logic [31:0] WINDOW_BASE_WMASK  = 32'hffffff80;
  localparam logic [7:0]  TENURE_TIMER_WMASK = 8'hf8;
  localparam int          WINDOW_FLAG_BIT    = 0;
  localparam int          MAP_KIND_LSB       = 1;
  localparam logic [7:0]  MAX_LAT_LOAD_MASK  = 8'h3e;
  localparam logic [7:0]  MIN_GNT_LOAD_MASK  = 8'hf0;

  // Positions within the EEPROM parameter word
  localparam int PARM_MAX_LAT_LSB   = 1;
  localparam int PARM_MIN_GNT_LSB   = 12;
  localparam int PARM_MEM_DIS_BIT   = 8;
  localparam int PARM_BELOW_1M_BIT  = 9;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        we;
    logic [5:0]  dword;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pchr_cfg_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } pchr_cfg_rsp_s;

endpackage : pchr_pkg

`default_nettype wire

// ---- dv/pchr_arbiter_model.sv ----
// Arbiter stand-in driving GNT# back to the register slice.
// Assumes the bench says when other requesters are waiting.
`timescale 1ns/1ps
`default_nettype none
module pchr_arbiter_model (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic others_waiting_i,
  output logic      gnt_n_o
);
  // Grant withdrawn only while someone else waits
  always_ff @(posedge clock_i) begin
    gnt_n_o <= rst_i ? 1'b0 : others_waiting_i;
  end
endmodule : pchr_arbiter_model
`default_nettype wire

// ---- dv/pchr_regs_asserts.sv ----
// Checker on the config header slice ports.
// Assumes one clock domain, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pchr_regs_asserts
  import pchr_pkg::*;
(
  input wire logic          clock_i,
  input wire logic          rst_i,
  input wire pchr_cfg_req_s cfg_req_i,
  input wire logic          cfg_ack_o,
  input wire logic [31:0]   cfg_rdata_o,
  input wire logic          parm_load_i,
  input wire logic [15:0]   eeprom_parameter_word_i,
  input wire logic          master_active_i,
  input wire logic          frame_start_i,
  input wire logic          gnt_n_i,
  input wire logic          tenure_expired_o,
  input wire logic          master_end_o,
  input wire logic          irq_req_i,
  input wire logic          inta_n_o,
  input wire logic          inta_n_oe_o,
  input wire logic [31:0]   io_window_base_o,
  input wire logic [31:0]   memory_window_base_o,
  input wire logic          memory_window_enable_o,
  input wire logic          below_one_megabyte_flag_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  sequence s_rd(logic [5:0] dw);
    cfg_req_i.req && !cfg_req_i.we && cfg_req_i.dword == dw;
  endsequence
  sequence s_wr(logic [5:0] dw);
    cfg_req_i.req && cfg_req_i.we && cfg_req_i.dword == dw && cfg_req_i.be == 4'hf;
  endsequence
  a_ack_after_req: assert property (cfg_req_i.req |=> cfg_ack_o) else $error("ack missing");
  a_no_stray_ack: assert property (!cfg_req_i.req |=> !cfg_ack_o) else $error("stray ack");
  a_rdata_idle_zero: assert property (!cfg_ack_o |-> cfg_rdata_o == 32'h0)
    else $error("rdata without ack");
  a_pin_reads_a: assert property (s_rd(6'h0f) |=> cfg_rdata_o[15:8] == 8'h01)
    else $error("interrupt pin code");
  a_cap_list_end: assert property (s_rd(6'h14) |=> cfg_rdata_o[15:8] == 8'h00)
    else $error("next pointer");
  a_io_flag_set: assert property (s_rd(6'h04) |=> cfg_rdata_o[6:0] == 7'h01)
    else $error("io low bits");
  a_window_low_clear: assert property (
    (io_window_base_o[6:0] | memory_window_base_o[6:0]) == 7'h0) else $error("window low bits");
  a_map_kind_read: assert property (s_rd(6'h05) ##0 memory_window_enable_o |=>
    cfg_rdata_o[2:0] == {1'b0, $past(below_one_megabyte_flag_o), 1'b1}) else $error("map kind");
  a_mem_disabled: assert property (s_rd(6'h05) ##0 !memory_window_enable_o |=>
    cfg_rdata_o == 32'h0) else $error("disabled window read");
  a_parm_load: assert property (parm_load_i |=>
    memory_window_enable_o == !$past(eeprom_parameter_word_i[PARM_MEM_DIS_BIT]) &&
    below_one_megabyte_flag_o == $past(eeprom_parameter_word_i[PARM_BELOW_1M_BIT]))
    else $error("parameter load");
  a_gnt_loss_end: assert property (master_end_o ==
    $past(master_active_i && tenure_expired_o && gnt_n_i)) else $error("master end");
  a_expired_holds: assert property (
    tenure_expired_o && master_active_i && !frame_start_i |=> tenure_expired_o)
    else $error("expiry dropped");
  a_irq_line_a: assert property (inta_n_oe_o == $past(irq_req_i) && !inta_n_o)
    else $error("interrupt drive");
  a_io_write_lands: assert property (s_wr(6'h04) |=>
    io_window_base_o == {$past(cfg_req_i.wdata[31:7]), 7'h00}) else $error("io window write");
  a_mem_write_lands: assert property (
    s_wr(6'h05) ##0 (memory_window_enable_o && !parm_load_i) |=>
    memory_window_base_o == {$past(cfg_req_i.wdata[31:7]), 7'h00})
    else $error("mem window write");
  a_mem_flag_set: assert property (s_rd(6'h05) ##0 memory_window_enable_o |=>
    cfg_rdata_o[0]) else $error("memory flag");
  a_timer_masked: assert property (s_rd(6'h03) |=> cfg_rdata_o[10:8] == 3'h0)
    else $error("timer low bits");
  a_min_gnt_low: assert property (s_rd(6'h0f) |=> cfg_rdata_o[19:16] == 4'h0)
    else $error("grant low bits");
  a_disabled_base: assert property (
    !memory_window_enable_o |-> memory_window_base_o == 32'h0) else $error("disabled base");
endmodule : pchr_regs_asserts
bind pchr_regs pchr_regs_asserts u_chk (.clock_i(clock_i), .rst_i(rst_i),
  .cfg_req_i(cfg_req_i), .cfg_ack_o(cfg_ack_o), .cfg_rdata_o(cfg_rdata_o),
  .parm_load_i(parm_load_i), .eeprom_parameter_word_i(eeprom_parameter_word_i),
  .master_active_i(master_active_i), .frame_start_i(frame_start_i), .gnt_n_i(gnt_n_i),
  .tenure_expired_o(tenure_expired_o), .master_end_o(master_end_o), .irq_req_i(irq_req_i),
  .inta_n_o(inta_n_o), .inta_n_oe_o(inta_n_oe_o), .io_window_base_o(io_window_base_o),
  .memory_window_base_o(memory_window_base_o),
  .memory_window_enable_o(memory_window_enable_o),
  .below_one_megabyte_flag_o(below_one_megabyte_flag_o));
`default_nettype wire

// ---- dv/pchr_regs_bench.sv ----
// Self-checking bench for the config header slice.
// Assumes the arbiter model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module pchr_regs_bench;
  import pchr_pkg::*;
  logic          clock_i, rst_i, parm_load_i, frame_start_i, master_active_i, irq_req_i;
  logic          others_waiting, gnt_n, ack, expired, mend, inta_n, inta_oe, mem_en, below;
  logic [15:0]   parm_word;
  logic [31:0]   rdata, io_base, mem_base;
  pchr_cfg_req_s cfg_req;
  int            fail_count = 0, cmp_count = 0, cycles = 0, k;
  pchr_regs i_dut (.clock_i(clock_i), .rst_i(rst_i), .cfg_req_i(cfg_req), .cfg_ack_o(ack),
    .cfg_rdata_o(rdata), .parm_load_i(parm_load_i), .eeprom_parameter_word_i(parm_word),
    .frame_start_i(frame_start_i), .master_active_i(master_active_i), .gnt_n_i(gnt_n),
    .tenure_expired_o(expired), .master_end_o(mend), .irq_req_i(irq_req_i),
    .inta_n_o(inta_n), .inta_n_oe_o(inta_oe), .io_window_base_o(io_base),
    .memory_window_base_o(mem_base), .memory_window_enable_o(mem_en),
    .below_one_megabyte_flag_o(below));
  pchr_arbiter_model i_arb (.clock_i(clock_i), .rst_i(rst_i),
    .others_waiting_i(others_waiting), .gnt_n_o(gnt_n));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic cfg_io(input logic we, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    cfg_req = '{req: 1'b1, we: we, dword: dw, be: be, wdata: wd};
    @(negedge clock_i);
    cfg_req.req = 1'b0;
    while (ack !== 1'b1 && n < 4) begin
      @(negedge clock_i);
      n++;
    end
    `CHK(ack, 1'b1, "ack missing")
    rd = rdata;
    // Idle edge, so a following call never re-raises req in this step
    @(negedge clock_i);
  endtask : cfg_io
  task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] unused;
    cfg_io(1'b1, dw, be, wd, unused);
  endtask : wr
  task automatic rd_chk(input logic [5:0] dw, input logic [31:0] exp);
    logic [31:0] got;
    cfg_io(1'b0, dw, 4'hf, 32'h0, got);
    `CHK(got, exp, "read data")
  endtask : rd_chk
  task automatic load(input logic [15:0] w);
    parm_word = w;
    parm_load_i = 1'b1;
    @(negedge clock_i);
    parm_load_i = 1'b0;
    @(negedge clock_i);
  endtask : load
  task automatic t_defaults();
    rd_chk(6'h03, 32'h00000000);
    rd_chk(6'h0f, 32'h0a000100);
    rd_chk(6'h04, 32'h00000001);
    rd_chk(6'h14, 32'h00000000);
    `CHK(mem_en, 1'b1, "window enable")
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_writes();
    wr(6'h04, 4'hf, 32'hffffffff);
    rd_chk(6'h04, 32'hffffff81);
    `CHK(io_base, 32'hffffff80, "io window")
    wr(6'h03, 4'h2, 32'hffffffff);
    rd_chk(6'h03, 32'h0000f800);
    wr(6'h0f, 4'hf, 32'hffffffff);
    rd_chk(6'h0f, 32'h0a000100);
    wr(6'h14, 4'hf, 32'hffffffff);
    rd_chk(6'h14, 32'h00000000);
    wr(6'h20, 4'hf, 32'hffffffff);
    rd_chk(6'h20, 32'h00000000);
    $display("test writes done");
  endtask : t_writes
  task automatic t_autoinit();
    load(16'ha23e);
    `CHK(below, 1'b1, "below flag")
    rd_chk(6'h0f, 32'h3ea00100);
    wr(6'h05, 4'hf, 32'hffffffff);
    rd_chk(6'h05, 32'hffffff83);
    `CHK(mem_base, 32'hffffff80, "mem window")
    load(16'h0100);
    `CHK(mem_en, 1'b0, "window enable")
    wr(6'h05, 4'hf, 32'hffffffff);
    rd_chk(6'h05, 32'h00000000);
    rd_chk(6'h0f, 32'h00000100);
    $display("test autoinit done");
  endtask : t_autoinit
  task automatic tenure_run();
    frame_start_i = 1'b1;
    @(negedge clock_i);
    frame_start_i = 1'b0;
    k = 0;
    while (expired !== 1'b1 && k < 40) begin
      k++;
      @(negedge clock_i);
    end
  endtask : tenure_run
  task automatic t_tenure();
    wr(6'h03, 4'h2, 32'h00000800);
    others_waiting = 1'b1;
    master_active_i = 1'b1;
    tenure_run();
    `CHK(k, 8, "tenure length")
    @(negedge clock_i);
    `CHK(mend, 1'b1, "master end")
    master_active_i = 1'b0;
    repeat (2) @(negedge clock_i);
    master_active_i = 1'b1;
    others_waiting = 1'b0;
    frame_start_i = 1'b1;
    @(negedge clock_i);
    frame_start_i = 1'b0;
    repeat (4) @(negedge clock_i);
    `CHK(expired, 1'b0, "early expiry")
    tenure_run();
    `CHK(k, 8, "reload length")
    repeat (2) @(negedge clock_i);
    `CHK(mend, 1'b0, "end while granted")
    others_waiting = 1'b1;
    @(negedge clock_i);
    `CHK(mend, 1'b0, "end before grant loss seen")
    @(negedge clock_i);
    `CHK(mend, 1'b1, "end after grant loss")
    master_active_i = 1'b0;
    $display("test tenure done");
  endtask : t_tenure
  task automatic t_irq_reset();
    irq_req_i = 1'b1;
    @(negedge clock_i);
    `CHK({inta_oe, inta_n}, 2'b10, "interrupt line")
    irq_req_i = 1'b0;
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    rd_chk(6'h0f, 32'h0a000100);
    `CHK(mem_en, 1'b1, "window enable")
    `CHK(io_base, 32'h00000000, "io window after reset")
    rd_chk(6'h03, 32'h00000000);
    $display("test irq and reset done");
  endtask : t_irq_reset
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    {rst_i, parm_load_i, frame_start_i, master_active_i, irq_req_i, others_waiting} = 6'h20;
    parm_word = 16'h0;
    cfg_req = '0;
    repeat (8) @(negedge clock_i);
    rst_i = 1'b0;
    t_defaults();
    t_writes();
    t_autoinit();
    t_tenure();
    t_irq_reset();
    report_and_stop();
  end
endmodule : pchr_regs_bench
`default_nettype wire
